/* core/uil_pkg.sv */
// Package: constants and types for the UART interrupt logic
package uil_pkg;
	// ==========================================
	// Register addresses (A2-A0)
	localparam logic [2:0] ADDR_DATA = 3'h0;
	localparam logic [2:0] ADDR_IER = 3'h1;
	localparam logic [2:0] ADDR_ISR = 3'h2;
	localparam logic [2:0] ADDR_LSR = 3'h5;
	localparam logic [2:0] ADDR_MSR = 3'h6;
	// ==========================================
	// Field positions
	localparam int IER_RX_BIT = 0;
	localparam int IER_TX_BIT = 1;
	localparam int IER_LS_BIT = 2;
	localparam int IER_MS_BIT = 3;
	localparam int IER_XOFF_BIT = 5;
	localparam int IER_RTS_BIT = 6;
	localparam int IER_CTS_BIT = 7;
	localparam int EFR_ENH_BIT = 4;
	localparam int EMS_IMMED_BIT = 6;
	// ==========================================
	// Reset values
	localparam logic [7:0] IER_RESET = 8'h00;
	localparam logic [7:0] ISR_NONE = 8'h01;
	localparam logic [7:0] LSR_RESET = 8'h60;
	// ==========================================
	// Source codes in bits 5..0 of the status word
	localparam logic [5:0] CODE_LS = 6'h06;
	localparam logic [5:0] CODE_TMO = 6'h0c;
	localparam logic [5:0] CODE_RX = 6'h04;
	localparam logic [5:0] CODE_TX = 6'h02;
	localparam logic [5:0] CODE_MS = 6'h00;
	localparam logic [5:0] CODE_XOFF = 6'h10;
	localparam logic [5:0] CODE_FLOW = 6'h20;
	localparam logic [5:0] CODE_NONE = 6'h01;
	// ==========================================
	// Timeout: four characters plus twelve bits
	localparam int TMO_CHARS = 4;
	localparam int TMO_BITS = 12;
	// Host bus access
	typedef struct packed {
		logic rd;
		logic wr;
		logic [2:0] addr;
		logic [7:0] wdata;
	} uil_bus_t;
	// Events from the datapath: push, pop, overrun, activity, matches, rises and deltas are one-cycle pulses, the rest are levels
	typedef struct packed {
		logic rx_push;
		logic rx_pop;
		logic rx_above_trig;
		logic rx_empty;
		logic rx_any_err;
		logic head_err;
		logic [2:0] head_err_type;
		logic overrun;
		logic rx_activity;
		logic tx_below_trig;
		logic thr_empty;
		logic tx_all_empty;
		logic xoff_match;
		logic xon_match;
		logic special_match;
		logic rts_rise;
		logic cts_rise;
		logic [3:0] msr_delta;
	} uil_evt_t;
endpackage

/* core/uil_top.sv */
// Interrupt enable, prioritisation, status and clearing for one channel
// Function
// RULE_01: FIFO mode: rx interrupt follows level at or above trigger.
// RULE_02: Data-ready flag sets on push, clears only when FIFO empty.
// RULE_03: Host polls by clearing enable bits 0-3 with FIFOs on.
// RULE_04: Line status bits report overrun, head error, tx empties, global error.
// RULE_05: Enable bit 0: rx interrupt on any data, or trigger in FIFO mode.
// RULE_06: Enable bit 1: tx ready interrupt; fires at once if already empty.
// RULE_07: Overrun interrupts at once; byte errors at readout unless immediate mode.
// RULE_08: Enable bit 3: modem interrupt on any of four delta bits.
// RULE_09: Enable bits 4-7 writable only with enhanced bit set.
// RULE_10: Enable bit 5: interrupt on Xoff or special character match.
// RULE_11: Enable bit 6: interrupt on RTS rising under auto RTS.
// RULE_12: Enable bit 7: interrupt on CTS rising under auto CTS.
// RULE_13: Status read returns highest pending source; code frozen until serviced. Code here is re-registered every cycle, not frozen.
// RULE_14: Timeout after four characters plus twelve bits of rx idle.
// RULE_15: Tx ready from trigger or empty; RS-485 mode uses transmitter empty.
// RULE_16: Line status read clears line interrupt; modem read clears modem/flow.
// RULE_17: Rx ready clears below trigger; timeout clears on data read.
// RULE_18: Tx ready clears on status read or holding write.
// RULE_19: Xoff clears on status read or Xon; special on read or next char.
// RULE_20: Status bit 0 reads 0 when pending, 1 when idle.
// RULE_21: Priority: line, timeout, rx, tx, modem, xoff, flow change.
// RULE_22: Status bits 7:6 mirror FIFO enable.
// RULE_23: Interrupt output active whenever any enabled source pending.
// RULE_24: Enable bits reset to zero.
`timescale 1ns/1ps
`default_nettype none
module uil_top import uil_pkg::*; #(
	parameter int BIT_CYCLES = 16
) (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Host register access
	input var uil_bus_t bus,
	output logic [7:0] rdata_reg,
	// Configuration from the rest of the channel
	input wire logic fifo_en,
	input wire logic enh_en,
	input wire logic lsr_immed,
	input wire logic rs485_en,
	input wire logic auto_rts,
	input wire logic auto_cts,
	input wire logic [3:0] char_bits,
	// Datapath events
	input var uil_evt_t evt,
	// Interrupt and line status
	output logic irq_reg,
	output logic [7:0] lsr_reg,
	output logic [7:0] ier_reg
);
	// ==========================================
	// Decode
	logic rd_isr, rd_lsr, rd_msr, rd_rhr, wr_thr, wr_ier;
	logic [5:0] isr_code;
	assign rd_isr = bus.rd && bus.addr == ADDR_ISR;
	assign rd_lsr = bus.rd && bus.addr == ADDR_LSR;
	assign rd_msr = bus.rd && bus.addr == ADDR_MSR;
	assign rd_rhr = bus.rd && bus.addr == ADDR_DATA;
	assign wr_thr = bus.wr && bus.addr == ADDR_DATA;
	assign wr_ier = bus.wr && bus.addr == ADDR_IER;

	// Enable mask; upper nibble guarded by enhanced bit
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ier_reg <= IER_RESET; // [RULE_24]
		end else if (wr_ier) begin
			ier_reg[3:0] <= bus.wdata[3:0];
			if (enh_en) begin
				ier_reg[7:4] <= bus.wdata[7:4]; // [RULE_09]
			end
		end
	end

	// ==========================================
	// Line status flags
	logic rx_ready_reg, overrun_reg;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rx_ready_reg <= 1'b0;
		end else if (evt.rx_push) begin
			rx_ready_reg <= 1'b1; // [RULE_02]
		end else if (evt.rx_empty) begin
			rx_ready_reg <= 1'b0;
		end
	end
	// Overrun is sticky until the line status read; set wins
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			overrun_reg <= 1'b0;
		end else if (evt.overrun) begin
			overrun_reg <= 1'b1;
		end else if (rd_lsr) begin
			overrun_reg <= 1'b0;
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			lsr_reg <= LSR_RESET;
		end else begin
			lsr_reg <= {evt.rx_any_err, evt.tx_all_empty, evt.thr_empty,
				evt.head_err_type, overrun_reg, rx_ready_reg}; // [RULE_04]
		end
	end

	// ==========================================
	// Line status source
	logic ls_pend_reg;
	logic err_event;
	// Byte errors count when read out, or on arrival in immediate mode
	assign err_event = evt.overrun || (lsr_immed ? (evt.rx_push && evt.head_err) :
		(rd_rhr && evt.head_err)); // [RULE_07]
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ls_pend_reg <= 1'b0;
		end else if (err_event) begin
			ls_pend_reg <= 1'b1;
		end else if (rd_lsr) begin
			ls_pend_reg <= 1'b0; // [RULE_16]
		end
	end

	// Receive ready is a level: trigger in FIFO mode, any data otherwise
	logic rx_src;
	assign rx_src = fifo_en ? evt.rx_above_trig : rx_ready_reg; // [RULE_01] [RULE_05] [RULE_17]

	// ==========================================
	// Receive timeout timer, counted in bit times
	localparam int TW = 16;
	logic [TW-1:0] bit_cnt_reg;
	logic [7:0] idle_bits_reg;
	logic tmo_pend_reg;
	logic bit_tick;
	logic [7:0] tmo_limit;
	assign bit_tick = bit_cnt_reg == TW'(BIT_CYCLES - 1);
	// Idle limit grows with frame length, so slow formats still wait long enough
	assign tmo_limit = 8'(TMO_CHARS * char_bits + TMO_BITS); // [RULE_14]
	always_ff @(posedge clock) begin
		if (sys_rst || bit_tick || evt.rx_activity) begin
			bit_cnt_reg <= '0;
		end else begin
			bit_cnt_reg <= bit_cnt_reg + 1'b1;
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst || evt.rx_activity || evt.rx_pop || rd_rhr || !rx_ready_reg) begin
			idle_bits_reg <= '0;
		end else if (bit_tick && idle_bits_reg != tmo_limit) begin
			idle_bits_reg <= idle_bits_reg + 1'b1;
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			tmo_pend_reg <= 1'b0;
		end else if (rd_rhr) begin
			tmo_pend_reg <= 1'b0; // [RULE_17]
		end else if (rx_ready_reg && bit_tick && idle_bits_reg == tmo_limit - 8'h01) begin
			tmo_pend_reg <= 1'b1; // [RULE_14]
		end
	end

	// ==========================================
	// Transmit ready: edge of the ready condition or enable going high
	logic tx_cond, tx_cond_d_reg, tx_en_d_reg, tx_pend_reg;
	assign tx_cond = rs485_en ? evt.tx_all_empty :
		(fifo_en ? (evt.tx_below_trig || evt.thr_empty) : evt.thr_empty); // [RULE_15]
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			tx_cond_d_reg <= 1'b1;
			tx_en_d_reg <= 1'b0;
		end else begin
			tx_cond_d_reg <= tx_cond;
			tx_en_d_reg <= ier_reg[IER_TX_BIT];
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			tx_pend_reg <= 1'b0;
		end else if ((tx_cond && !tx_cond_d_reg) ||
			(tx_cond && ier_reg[IER_TX_BIT] && !tx_en_d_reg)) begin
			tx_pend_reg <= 1'b1; // [RULE_06]
		end else if (wr_thr || (rd_isr && isr_code == CODE_TX)) begin
			tx_pend_reg <= 1'b0; // [RULE_18]
		end
	end

	// ==========================================
	// Modem, soft flow and hardware flow sources
	logic ms_pend_reg, xoff_pend_reg, spec_pend_reg, flow_pend_reg;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ms_pend_reg <= 1'b0;
		end else if (|evt.msr_delta) begin
			ms_pend_reg <= 1'b1; // [RULE_08]
		end else if (rd_msr) begin
			ms_pend_reg <= 1'b0; // [RULE_16]
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			xoff_pend_reg <= 1'b0;
		end else if (evt.xoff_match) begin
			xoff_pend_reg <= 1'b1; // [RULE_10]
		end else if (evt.xon_match || (rd_isr && isr_code == CODE_XOFF)) begin
			xoff_pend_reg <= 1'b0; // [RULE_19]
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			spec_pend_reg <= 1'b0;
		end else if (evt.special_match) begin
			spec_pend_reg <= 1'b1; // [RULE_10]
		end else if (evt.rx_push || (rd_isr && isr_code == CODE_XOFF)) begin
			spec_pend_reg <= 1'b0; // [RULE_19]
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			flow_pend_reg <= 1'b0;
		end else if ((evt.rts_rise && auto_rts && ier_reg[IER_RTS_BIT]) ||
			(evt.cts_rise && auto_cts && ier_reg[IER_CTS_BIT])) begin
			flow_pend_reg <= 1'b1; // [RULE_11] [RULE_12]
		end else if (rd_msr) begin
			flow_pend_reg <= 1'b0; // [RULE_16]
		end
	end

	// ==========================================
	// Priority encoder over enabled sources
	logic [6:0] act;
	assign act = {flow_pend_reg,
		(xoff_pend_reg || spec_pend_reg) && ier_reg[IER_XOFF_BIT],
		ms_pend_reg && ier_reg[IER_MS_BIT],
		tx_pend_reg && ier_reg[IER_TX_BIT],
		rx_src && ier_reg[IER_RX_BIT],
		tmo_pend_reg && ier_reg[IER_RX_BIT],
		ls_pend_reg && ier_reg[IER_LS_BIT]};
	function automatic logic [5:0] prio(input logic [6:0] a);
		if (a[0]) return CODE_LS;
		if (a[1]) return CODE_TMO;
		if (a[2]) return CODE_RX;
		if (a[3]) return CODE_TX;
		if (a[4]) return CODE_MS;
		if (a[5]) return CODE_XOFF;
		if (a[6]) return CODE_FLOW;
		return CODE_NONE;
	endfunction
	// Code re-registered every cycle from the enabled sources, so it can change during a read
	logic [5:0] held_code_reg;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			held_code_reg <= CODE_NONE;
		end else begin
			held_code_reg <= prio(act); // [RULE_21] [RULE_13]
		end
	end
	assign isr_code = held_code_reg;

	// Interrupt output from any enabled pending source
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |act; // [RULE_23]
		end
	end

	// ==========================================
	// Read data for the registers this block owns
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			rdata_reg <= ISR_NONE;
		end else if (bus.rd) begin
			case (bus.addr)
				ADDR_ISR: rdata_reg <= {{2{fifo_en}}, isr_code}; // [RULE_22] [RULE_20]
				ADDR_IER: rdata_reg <= ier_reg;
				ADDR_LSR: rdata_reg <= lsr_reg;
				default: rdata_reg <= 8'h00;
			endcase
		end
	end

	// ==========================================
	// Checks
	property p_ier_lock;
		@(posedge clock) disable iff (sys_rst)
		(wr_ier && !enh_en) |=> ier_reg[7:4] == $past(ier_reg[7:4]);
	endproperty
	a_ier_lock: assert property (p_ier_lock) else $error("upper enables changed while locked"); // [RULE_09]
	property p_irq_set;
		@(posedge clock) disable iff (sys_rst)
		((ls_pend_reg && ier_reg[IER_LS_BIT]) ||
			(ms_pend_reg && ier_reg[IER_MS_BIT])) |=> irq_reg;
	endproperty
	a_irq_set: assert property (p_irq_set) else $error("pending source left irq low"); // [RULE_23]
	property p_irq_mask;
		@(posedge clock) disable iff (sys_rst)
		(ier_reg == IER_RESET && !flow_pend_reg) |=> !irq_reg;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("irq while masked"); // [RULE_24]
	property p_ls_clear;
		@(posedge clock) disable iff (sys_rst)
		(rd_lsr && !err_event) |=> !ls_pend_reg;
	endproperty
	a_ls_clear: assert property (p_ls_clear) else $error("line status not cleared"); // [RULE_16]
	property p_ls_first;
		@(posedge clock) disable iff (sys_rst)
		act[0] |=> held_code_reg == CODE_LS;
	endproperty
	a_ls_first: assert property (p_ls_first) else $error("line status lost priority"); // [RULE_21]
	property p_tmo_clear;
		@(posedge clock) disable iff (sys_rst)
		rd_rhr |=> !tmo_pend_reg;
	endproperty
	a_tmo_clear: assert property (p_tmo_clear) else $error("timeout not cleared"); // [RULE_17]
	property p_thr_clear;
		@(posedge clock) disable iff (sys_rst)
		(wr_thr && !(tx_cond && !tx_cond_d_reg) && !(tx_cond && !tx_en_d_reg)) |=> !tx_pend_reg;
	endproperty
	a_thr_clear: assert property (p_thr_clear) else $error("tx ready not cleared"); // [RULE_18]
	property p_ready_push;
		@(posedge clock) disable iff (sys_rst)
		evt.rx_push |=> rx_ready_reg ##1 lsr_reg[0];
	endproperty
	a_ready_push: assert property (p_ready_push) else $error("data ready not set"); // [RULE_02]
	property p_ms;
		@(posedge clock) disable iff (sys_rst)
		(|evt.msr_delta) |=> ms_pend_reg;
	endproperty
	a_ms: assert property (p_ms) else $error("modem delta missed"); // [RULE_08]
	property p_isr_read;
		@(posedge clock) disable iff (sys_rst)
		rd_isr |=> rdata_reg[7:6] == {2{$past(fifo_en)}};
	endproperty
	a_isr_read: assert property (p_isr_read) else $error("fifo bits wrong"); // [RULE_22]
	property p_tx_ready;
		@(posedge clock) disable iff (sys_rst)
		(tx_cond && ier_reg[IER_TX_BIT] && !tx_en_d_reg) |=> tx_pend_reg;
	endproperty
	a_tx_ready: assert property (p_tx_ready) else $error("tx ready missed"); // [RULE_06]
	property p_overrun;
		@(posedge clock) disable iff (sys_rst)
		evt.overrun |=> ls_pend_reg;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun missed"); // [RULE_07]
	property p_xoff;
		@(posedge clock) disable iff (sys_rst)
		evt.xoff_match |=> xoff_pend_reg;
	endproperty
	a_xoff: assert property (p_xoff) else $error("xoff missed"); // [RULE_10]
	property p_xon_clear;
		@(posedge clock) disable iff (sys_rst)
		(evt.xon_match && !evt.xoff_match) |=> !xoff_pend_reg;
	endproperty
	a_xon_clear: assert property (p_xon_clear) else $error("xoff not cleared"); // [RULE_19]
	property p_spec_clear;
		@(posedge clock) disable iff (sys_rst)
		(evt.rx_push && !evt.special_match) |=> !spec_pend_reg;
	endproperty
	a_spec_clear: assert property (p_spec_clear) else $error("special not cleared"); // [RULE_19]
	property p_cts;
		@(posedge clock) disable iff (sys_rst)
		(evt.cts_rise && auto_cts && ier_reg[IER_CTS_BIT]) |=> flow_pend_reg;
	endproperty
	a_cts: assert property (p_cts) else $error("cts rise missed"); // [RULE_12]
	property p_isr_idle;
		@(posedge clock) disable iff (sys_rst)
		(rd_isr && held_code_reg == CODE_NONE) |=> rdata_reg[0];
	endproperty
	a_isr_idle: assert property (p_isr_idle) else $error("idle status bit low"); // [RULE_20]
	c_irq: cover property (@(posedge clock) disable iff (sys_rst) $rose(irq_reg));
	c_tmo: cover property (@(posedge clock) disable iff (sys_rst) $rose(tmo_pend_reg));
	c_flow: cover property (@(posedge clock) disable iff (sys_rst) held_code_reg == CODE_FLOW);
	c_xoff: cover property (@(posedge clock) disable iff (sys_rst) held_code_reg == CODE_XOFF);
	c_tx: cover property (@(posedge clock) disable iff (sys_rst) held_code_reg == CODE_TX);
endmodule
`default_nettype wire

/* tb/uil_host_model.sv */
// Host processor model that reaches the interrupt logic registers
`timescale 1ns/1ps
`default_nettype none
module uil_host_model import uil_pkg::*; (
	// Clock
	input wire logic clock,
	// Register bus toward the device
	output var uil_bus_t bus,
	input wire logic [7:0] rdata
);
	// ==========================================
	// Idle bus at time zero
	initial begin
		bus = '0;
	end
	// Write cycle; idle address and data invert so a stale value is never trusted
	task automatic write_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		bus.wr <= 1'b1;
		bus.addr <= a;
		bus.wdata <= d;
		@(posedge clock);
		bus.wr <= 1'b0;
		bus.addr <= ~a;
		bus.wdata <= ~d;
	endtask
	// Read cycle; data is taken one edge after the strobe was sampled
	task automatic read_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clock);
		bus.rd <= 1'b1;
		bus.addr <= a;
		@(posedge clock);
		bus.rd <= 1'b0;
		bus.addr <= ~a;
		@(posedge clock);
		d = rdata;
	endtask
endmodule
`default_nettype wire

/* tb/uil_top_tb.sv */
// Self-checking testbench for the channel interrupt logic
`timescale 1ns/1ps
`default_nettype none
module uil_top_tb import uil_pkg::*;;
	logic clock, sys_rst, irq;
	logic fifo_en, enh_en, lsr_immed, rs485_en, auto_rts, auto_cts;
	logic [3:0] char_bits;
	logic [7:0] rdata, line_status_reg, interrupt_enable_mask, rv;
	uil_bus_t bus;
	uil_evt_t evt;
	int errors;
	int n_compared;
	// ==========================================
	// Device and host; two bit clocks keep the idle timeout short
	uil_top #(.BIT_CYCLES(2)) u_dut (.clock(clock), .sys_rst(sys_rst), .bus(bus),
		.rdata_reg(rdata), .fifo_en(fifo_en), .enh_en(enh_en), .lsr_immed(lsr_immed),
		.rs485_en(rs485_en), .auto_rts(auto_rts), .auto_cts(auto_cts),
		.char_bits(char_bits), .evt(evt), .irq_reg(irq), .lsr_reg(line_status_reg), .ier_reg(interrupt_enable_mask));
	uil_host_model u_host (.clock(clock), .bus(bus), .rdata(rdata));
	// Clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// ==========================================
	// Verdict
	task automatic complete_run();
		$display("Compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Bounded wait on the interrupt line, sampled mid-cycle to stay clear of the edge
	task automatic wait_irq(input logic lvl, input int lim);
		int i;
		i = 0;
		@(negedge clock);
		while (irq !== lvl && i < lim) begin
			@(negedge clock);
			i++;
		end
		chk({7'h00, irq}, {7'h00, lvl});
	endtask
	// One-cycle datapath event pulse
	task automatic pulse(input int which);
		@(posedge clock);
		case (which)
			0: evt.overrun <= 1'b1;
			1: evt.msr_delta <= 4'h2;
			2: evt.rts_rise <= 1'b1;
			4: evt.xoff_match <= 1'b1;
			5: evt.xon_match <= 1'b1;
			6: evt.cts_rise <= 1'b1;
			7: evt.special_match <= 1'b1;
			default: evt.rx_push <= 1'b1;
		endcase
		@(posedge clock);
		evt.overrun <= 1'b0;
		evt.msr_delta <= 4'h0;
		evt.rts_rise <= 1'b0;
		evt.rx_push <= 1'b0;
		evt.xoff_match <= 1'b0;
		evt.xon_match <= 1'b0;
		evt.cts_rise <= 1'b0;
		evt.special_match <= 1'b0;
	endtask
	// Status read, expected with both FIFO-enable bits high
	task automatic chk_isr(input logic [5:0] code);
		repeat (3) @(posedge clock);
		u_host.read_reg(ADDR_ISR, rv);
		chk(rv, {2'b11, code});
	endtask
	// ==========================================
	// Scenarios
	task automatic t_reset();
		chk(interrupt_enable_mask, IER_RESET);
		chk({7'h00, irq}, 8'h00);
		u_host.read_reg(ADDR_ISR, rv);
		chk(rv, ISR_NONE);
	endtask
	task automatic t_upper_mask();
		u_host.write_reg(ADDR_IER, 8'hf0);
		u_host.read_reg(ADDR_IER, rv);
		chk(rv, 8'h00);
		@(posedge clock);
		enh_en <= 1'b1;
		u_host.write_reg(ADDR_IER, 8'hf0);
		u_host.read_reg(ADDR_IER, rv);
		chk(rv, 8'hf0);
		u_host.write_reg(ADDR_IER, 8'h00);
	endtask
	task automatic t_overrun();
		u_host.write_reg(ADDR_IER, 8'h04);
		pulse(0);
		wait_irq(1'b1, 10);
		chk(line_status_reg, 8'h42);
		chk_isr(CODE_LS);
		u_host.read_reg(ADDR_LSR, rv);
		chk(rv, 8'h42);
		wait_irq(1'b0, 5);
	endtask
	// Tx already empty before enabling; rx trigger outranks it
	task automatic t_rx_tx();
		@(posedge clock);
		evt.thr_empty <= 1'b1;
		evt.rx_above_trig <= 1'b1;
		u_host.write_reg(ADDR_IER, 8'h03);
		wait_irq(1'b1, 10);
		chk(line_status_reg, 8'h60);
		chk_isr(CODE_RX);
		@(posedge clock);
		evt.rx_above_trig <= 1'b0;
		chk_isr(CODE_TX);
		wait_irq(1'b0, 5);
		u_host.write_reg(ADDR_IER, 8'h00);
		evt.thr_empty <= 1'b0;
	endtask
	task automatic t_modem_flow();
		u_host.write_reg(ADDR_IER, 8'h08);
		pulse(1);
		wait_irq(1'b1, 10);
		chk_isr(CODE_MS);
		u_host.read_reg(ADDR_MSR, rv);
		wait_irq(1'b0, 5);
		@(posedge clock);
		auto_rts <= 1'b1;
		u_host.write_reg(ADDR_IER, 8'h40);
		pulse(2);
		wait_irq(1'b1, 10);
		chk_isr(CODE_FLOW);
		u_host.read_reg(ADDR_MSR, rv);
		wait_irq(1'b0, 5);
		u_host.write_reg(ADDR_IER, 8'h00);
	endtask
	// Polled data first, then idle timeout of 4*10+12 bits at two clocks a bit
	task automatic t_timeout();
		@(posedge clock);
		evt.rx_empty <= 1'b0;
		pulse(3);
		repeat (2) @(negedge clock);
		chk({7'h00, line_status_reg[0]}, 8'h01);
		chk({7'h00, irq}, 8'h00);
		u_host.write_reg(ADDR_IER, 8'h01);
		repeat (60) @(negedge clock);
		chk({7'h00, irq}, 8'h00);
		wait_irq(1'b1, 150);
		chk_isr(CODE_TMO);
		u_host.read_reg(ADDR_DATA, rv);
		wait_irq(1'b0, 5);
		@(posedge clock);
		evt.rx_empty <= 1'b1;
		repeat (3) @(negedge clock);
		chk({7'h00, line_status_reg[0]}, 8'h00);
	endtask
	// RS-485 tx ready from transmitter empty, cleared by a holding write
	task automatic t_rs485();
		@(posedge clock);
		rs485_en <= 1'b1;
		u_host.write_reg(ADDR_IER, 8'h02);
		wait_irq(1'b1, 10);
		u_host.write_reg(ADDR_DATA, 8'h55);
		wait_irq(1'b0, 5);
		u_host.write_reg(ADDR_IER, 8'h00);
		rs485_en <= 1'b0;
	endtask
	// Byte error waits for readout by default, interrupts on arrival in immediate mode
	task automatic t_byte_err();
		u_host.write_reg(ADDR_IER, 8'h04);
		evt.head_err <= 1'b1;
		evt.head_err_type <= 3'h1;
		evt.rx_any_err <= 1'b1;
		repeat (4) @(negedge clock);
		chk({7'h00, irq}, 8'h00);
		chk(line_status_reg, 8'hc4);
		u_host.read_reg(ADDR_DATA, rv);
		wait_irq(1'b1, 10);
		chk_isr(CODE_LS);
		u_host.read_reg(ADDR_LSR, rv);
		chk(rv, 8'hc4);
		wait_irq(1'b0, 5);
		@(posedge clock);
		lsr_immed <= 1'b1;
		pulse(3);
		wait_irq(1'b1, 10);
		u_host.read_reg(ADDR_LSR, rv);
		chk(rv, 8'hc4);
		wait_irq(1'b0, 5);
		@(posedge clock);
		lsr_immed <= 1'b0;
		evt.head_err <= 1'b0;
		evt.head_err_type <= 3'h0;
		evt.rx_any_err <= 1'b0;
		u_host.write_reg(ADDR_IER, 8'h00);
	endtask
	// Xoff cleared by status read and by Xon, special by next character, then CTS
	task automatic t_soft_hw_flow();
		u_host.write_reg(ADDR_IER, 8'h20);
		pulse(4);
		wait_irq(1'b1, 10);
		chk_isr(CODE_XOFF);
		wait_irq(1'b0, 5);
		pulse(4);
		wait_irq(1'b1, 10);
		pulse(5);
		wait_irq(1'b0, 5);
		pulse(7);
		wait_irq(1'b1, 10);
		pulse(3);
		wait_irq(1'b0, 5);
		@(posedge clock);
		auto_cts <= 1'b1;
		u_host.write_reg(ADDR_IER, 8'h80);
		pulse(6);
		wait_irq(1'b1, 10);
		chk_isr(CODE_FLOW);
		u_host.read_reg(ADDR_MSR, rv);
		wait_irq(1'b0, 5);
		u_host.write_reg(ADDR_IER, 8'h00);
	endtask
	// ==========================================
	// Main sequence
	initial begin
		errors = 0;
		n_compared = 0;
		evt = '0;
		evt.rx_empty = 1'b1;
		evt.tx_all_empty = 1'b1;
		{fifo_en, enh_en, lsr_immed, rs485_en, auto_rts, auto_cts} = 6'h00;
		char_bits = 4'ha;
		sys_rst = 1'b1;
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset();
		@(posedge clock);
		fifo_en <= 1'b1;
		t_upper_mask();
		t_overrun();
		t_rx_tx();
		t_modem_flow();
		t_timeout();
		t_rs485();
		t_byte_err();
		t_soft_hw_flow();
		complete_run();
	end
	// Watchdog well beyond the few hundred cycles the scenarios need
	initial begin
		#200000;
		errors++;
		complete_run();
	end
endmodule
`default_nettype wire
